// ### logic/tmcc_core.sv
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module tmcc_core
  import tmcc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire tmcc_bus_t  bus,
  output logic [7:0]      rdata,
  input  wire logic       high_internal_tick,
  input  wire logic       low_speed_tick,
  input  wire logic       timer_clock_input_pin,
  output logic            timer_output_pin,
  output logic            irq_a,
  output logic            irq_p
);
  ////////////////////////////////////////////////////////////////////
  tmcc_ctrl0_t c0_ff;
  tmcc_ctrl1_t c1_ff;
  logic [15:0] cnt_ff, cmpa_ff, cmpp_ff, nxt_cnt;
  logic [7:0]  buf_ff, nxt_buf;
  logic [2:0]  pin_sync_ff;
  logic        pin_ff, on_d_ff, out_ff, nxt_out, pa_ff, pp_ff, armed_ff;
  logic [5:0]  sdiv_ff, hdiv_ff;

  // Register decode
  wire wr_c0  = bus.wr && bus.addr == ADDR_CTRL0;
  wire wr_c1  = bus.wr && bus.addr == ADDR_CTRL1;
  wire wr_alo = bus.wr && bus.addr == ADDR_CMPA_LO;
  wire wr_ahi = bus.wr && bus.addr == ADDR_CMPA_HI;
  wire wr_plo = bus.wr && bus.addr == ADDR_CMPP_LO;
  wire wr_phi = bus.wr && bus.addr == ADDR_CMPP_HI;
  wire wr_flg = bus.wr && bus.addr == ADDR_FLAGS;
  wire rd_dhi = bus.rd && bus.addr == ADDR_CNT_HI;
  wire rd_ahi = bus.rd && bus.addr == ADDR_CMPA_HI;
  wire rd_phi = bus.rd && bus.addr == ADDR_CMPP_HI;

  ////////////////////////////////////////////////////////////////////
  // Pin sampling, the second and third stages must agree
  wire pin_stable = pin_sync_ff[1] == pin_sync_ff[2];
  wire pin_rise   = pin_stable && pin_sync_ff[2] && !pin_ff;
  wire pin_fall   = pin_stable && !pin_sync_ff[2] && pin_ff;
  wire pin_edge   = c0_ff.counter_clock_select[0] ? pin_fall : pin_rise;

  // Clock tick selection
  wire [2:0] sel = c0_ff.counter_clock_select;
  wire sys4  = sdiv_ff[1:0] == DIV4_LAST[1:0];
  wire h16   = high_internal_tick && hdiv_ff[3:0] == DIV16_LAST[3:0];
  wire h64   = high_internal_tick && hdiv_ff == DIV64_LAST;
  logic tick;
  always_comb begin
    unique case (sel)
      3'b000: tick = sys4;
      3'b001: tick = 1'b1;
      3'b010: tick = h16;
      3'b011: tick = h64;
      3'b100,
      3'b101: tick = low_speed_tick;
      default: tick = pin_edge;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Counting and matches
  wire on_rise  = c0_ff.counter_on_bit && !on_d_ff;
  wire pin_trig = (sel[2] && sel[1]) ? pin_edge : 1'b0;
  wire is_pulse = c1_ff.mode == TMCC_MODE_PULSE;
  wire run      = c0_ff.counter_on_bit && !c0_ff.pause && (!is_pulse || armed_ff);
  wire step     = run && tick && !(is_pulse && sel[2] && sel[1]);
  wire cnt_step = is_pulse ? (run && (sel[2] && sel[1] ? 1'b1 : tick)) : step;
  wire match_a  = cnt_step && cnt_ff == cmpa_ff;
  wire match_p  = cnt_step && cnt_ff[15:8] == cmpp_ff[7:0];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (on_rise)
      nxt_cnt = 16'h0000;
    else if (cnt_step) begin
      if ((c1_ff.clear_on_a && match_a) || (!c1_ff.clear_on_a && match_p))
        nxt_cnt = 16'h0000;
      else
        nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  // Output pin
  always_comb begin
    nxt_out = out_ff;
    if (on_rise)
      nxt_out = c1_ff.out_init;
    else if (c1_ff.mode == TMCC_MODE_CMP && match_a) begin
      unique case (c1_ff.pin_func)
        2'b00: nxt_out = out_ff;
        2'b01: nxt_out = 1'b0;
        2'b10: nxt_out = 1'b1;
        2'b11: nxt_out = !out_ff;
      endcase
    end else if (c1_ff.mode == TMCC_MODE_PWM && c0_ff.counter_on_bit) begin
      unique case (c1_ff.pin_func)
        2'b00: nxt_out = !c1_ff.out_init;
        2'b01: nxt_out = c1_ff.out_init;
        2'b10: nxt_out = (nxt_cnt < (c1_ff.clear_on_a ? cmpp_ff : cmpa_ff))
                         ? c1_ff.out_init : !c1_ff.out_init;
        2'b11: nxt_out = out_ff;
      endcase
    end else if (is_pulse && (match_a || match_p))
      nxt_out = !c1_ff.out_init;
    else if (is_pulse && pin_trig && !armed_ff)
      nxt_out = c1_ff.out_init;
  end
  assign timer_output_pin = out_ff ^ c1_ff.out_pol;

  ////////////////////////////////////////////////////////////////////
  // Holding buffer
  always_comb begin
    nxt_buf = buf_ff;
    if (wr_alo || wr_plo)
      nxt_buf = bus.wdata;
    else if (rd_dhi)
      nxt_buf = cnt_ff[7:0];
    else if (rd_ahi)
      nxt_buf = cmpa_ff[7:0];
    else if (rd_phi)
      nxt_buf = cmpp_ff[7:0];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_ff <= 3'b000;
      pin_ff      <= 1'b0;
      sdiv_ff     <= 6'h00;
      hdiv_ff     <= 6'h00;
      on_d_ff     <= 1'b0;
      armed_ff    <= 1'b0;
    end else if (clk_en) begin
      pin_sync_ff <= {pin_sync_ff[1:0], timer_clock_input_pin};
      if (pin_stable)
        pin_ff <= pin_sync_ff[2];
      sdiv_ff     <= sdiv_ff + 6'h01;
      if (high_internal_tick)
        hdiv_ff <= hdiv_ff + 6'h01;
      on_d_ff     <= c0_ff.counter_on_bit;
      if (!is_pulse || on_rise || match_a || match_p)
        armed_ff <= 1'b0;
      else if (pin_trig)
        armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      c0_ff   <= CTRL0_RST;
      c1_ff   <= CTRL1_RST;
      cnt_ff  <= 16'h0000;
      cmpa_ff <= CMP_RST;
      cmpp_ff <= CMP_RST;
      buf_ff  <= 8'h00;
      out_ff  <= 1'b0;
    end else if (clk_en) begin
      if (wr_c0)
        c0_ff <= {bus.wdata[7:3], 3'b000};
      if (wr_c1)
        c1_ff <= bus.wdata;
      if (wr_ahi)
        cmpa_ff <= {bus.wdata, buf_ff};
      if (wr_phi)
        cmpp_ff <= {bus.wdata, buf_ff};
      cnt_ff  <= nxt_cnt;
      buf_ff  <= nxt_buf;
      out_ff  <= nxt_out;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pending flags, a new match wins over a clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pa_ff <= 1'b0;
      pp_ff <= 1'b0;
    end else if (clk_en) begin
      pa_ff <= match_a | (pa_ff & ~(wr_flg & bus.wdata[0]));
      pp_ff <= match_p | (pp_ff & ~(wr_flg & bus.wdata[1]));
    end
  end
  assign irq_a = pa_ff;
  assign irq_p = pp_ff;

  ////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    unique case (bus.addr)
      ADDR_CTRL0:   rd_mux = c0_ff;
      ADDR_CTRL1:   rd_mux = c1_ff;
      ADDR_CNT_LO,
      ADDR_CMPA_LO,
      ADDR_CMPP_LO: rd_mux = buf_ff;
      ADDR_CNT_HI:  rd_mux = cnt_ff[15:8];
      ADDR_CMPA_HI: rd_mux = cmpa_ff[15:8];
      ADDR_CMPP_HI: rd_mux = cmpp_ff[15:8];
      ADDR_FLAGS:   rd_mux = {6'h00, pp_ff, pa_ff};
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      rdata <= 8'h00;
    else if (clk_en)
      rdata <= bus.rd ? rd_mux : 8'h00;
  end
endmodule : tmcc_core

// ### logic/tmcc_pkg.sv
package tmcc_pkg;
  localparam logic [3:0] ADDR_CTRL0   = 4'h0;
  localparam logic [3:0] ADDR_CTRL1   = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO  = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI  = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
  localparam logic [3:0] ADDR_CMPP_LO = 4'h6;
  localparam logic [3:0] ADDR_CMPP_HI = 4'h7;
  localparam logic [3:0] ADDR_FLAGS   = 4'h8;
  localparam logic [7:0] CTRL0_RST    = 8'h00;
  localparam logic [7:0] CTRL1_RST    = 8'h00;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam logic [5:0] DIV4_LAST   = 6'h03;
  localparam logic [5:0] DIV16_LAST  = 6'h0f;
  localparam logic [5:0] DIV64_LAST  = 6'h3f;

  typedef enum logic [1:0] {
    TMCC_MODE_CMP    = 2'b00,
    TMCC_MODE_PULSE  = 2'b01,
    TMCC_MODE_PWM    = 2'b10,
    TMCC_MODE_TIMER  = 2'b11
  } tmcc_mode_t;

  typedef struct packed {
    logic       pause;
    logic [2:0] counter_clock_select;
    logic       counter_on_bit;
    logic [2:0] rsvd;
  } tmcc_ctrl0_t;

  typedef struct packed {
    tmcc_mode_t mode;
    logic [1:0] pin_func;
    logic       out_init;
    logic       out_pol;
    logic       rsvd;
    logic       clear_on_a;
  } tmcc_ctrl1_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmcc_bus_t;
endpackage : tmcc_pkg

// ### tb/tmcc_core_monitor.sv
`timescale 1ns/1ps
module tmcc_core_monitor
  import tmcc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire tmcc_bus_t  bus,
  input wire logic [7:0] rdata,
  input wire logic       timer_output_pin,
  input wire logic       irq_a,
  input wire logic       irq_p
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  rd_idle_a: assert property ($past(clk_en) && !$past(bus.rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  unmapped_rd_a: assert property (clk_en && bus.rd && bus.addr > ADDR_FLAGS |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl_rsvd_a: assert property (clk_en && bus.rd && bus.addr == ADDR_CTRL0 |=> rdata[2:0] == 3'h0)
    else $error("ctrl0 low bits not zero");
  a_sticky_a: assert property ($fell(irq_a) |->
    $past(clk_en && bus.wr && bus.addr == ADDR_FLAGS && bus.wdata[0]))
    else $error("flag a dropped alone");
  p_sticky_a: assert property ($fell(irq_p) |->
    $past(clk_en && bus.wr && bus.addr == ADDR_FLAGS && bus.wdata[1]))
    else $error("flag p dropped alone");
  freeze_a: assert property (!clk_en |=> $stable(rdata) && $stable(irq_a) && $stable(irq_p)
    && $stable(timer_output_pin))
    else $error("state moved while frozen");
  a_cause_a: assert property ($rose(irq_a) |-> $past(clk_en))
    else $error("flag a set while frozen");
  p_cause_a: assert property ($rose(irq_p) |-> $past(clk_en))
    else $error("flag p set while frozen");
  cover property ($rose(irq_a));
  cover property ($rose(irq_p));
  cover property ($rose(timer_output_pin));
endmodule : tmcc_core_monitor

// ### tb/tmcc_core_tb_top.sv
`timescale 1ns/1ps
module tmcc_core_tb_top
  import tmcc_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       nrst    = 1'b0;
  logic       clk_en  = 1'b1;
  tmcc_bus_t  bus     = '0;
  logic       hi_tick = 1'b1;
  logic       lo_tick = 1'b0;
  logic       pin_in  = 1'b0;
  logic [7:0] rdata, d, h;
  logic       pin_out, irq_a, irq_p;
  int         fail_count = 0;
  int         cmp_count  = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) lo_tick <= ~lo_tick;
  tmcc_core tmcc_core_inst (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .high_internal_tick(hi_tick), .low_speed_tick(lo_tick),
    .timer_clock_input_pin(pin_in), .timer_output_pin(pin_out), .irq_a(irq_a), .irq_p(irq_p));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic t_regs();
    rd(ADDR_CTRL0, d);
    chk("ctrl0", CTRL0_RST, d);
    rd(ADDR_CTRL1, d);
    chk("ctrl1", CTRL1_RST, d);
    wr(4'ha, 8'h5a);
    rd(4'ha, d);
    chk("unmapped", 8'h00, d);
    clk_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    clk_en <= 1'b1;
  endtask : t_regs
  task automatic t_buf();
    wr(ADDR_CMPA_LO, 8'h34);
    wr(ADDR_CMPA_HI, 8'h12);
    wr(ADDR_CMPA_LO, 8'h56);
    rd(ADDR_CMPA_HI, d);
    chk("cmpa hi", 8'h12, d);
    rd(ADDR_CMPA_LO, d);
    chk("cmpa lo", 8'h34, d);
  endtask : t_buf
  task automatic t_match();
    wr(ADDR_CMPA_LO, 8'h05);
    wr(ADDR_CMPA_HI, 8'h00);
    wr(ADDR_CTRL1, 8'h21);
    wr(ADDR_CTRL0, 8'h18);
    repeat (20) @(posedge ref_clk);
    chk("pin set", 8'h01, {7'h0, pin_out});
    chk("irq a", 8'h01, {7'h0, irq_a});
    chk("irq p", 8'h01, {7'h0, irq_p});
    wr(ADDR_CTRL0, 8'h10);
    rd(ADDR_CNT_HI, h);
    rd(ADDR_CNT_LO, d);
    chk("cnt wrap", 8'h01, {7'h0, {h, d} <= 16'h0005});
    wr(ADDR_FLAGS, 8'h03);
    #1 chk("flags clr", 8'h00, {6'h0, irq_p, irq_a});
    wr(ADDR_CTRL0, 8'h18);
    @(posedge ref_clk);
    #1 chk("pin init", 8'h00, {7'h0, pin_out});
    wr(ADDR_CTRL0, 8'h10);
  endtask : t_match
  task automatic t_edge(input logic [2:0] sel, input logic lvl);
    wr(ADDR_CMPA_LO, 8'hff);
    wr(ADDR_CMPA_HI, 8'hff);
    wr(ADDR_CTRL1, 8'hc1);
    pin_in <= lvl;
    wr(ADDR_CTRL0, {1'b0, sel, 4'h8});
    repeat (3) begin
      repeat (10) @(posedge ref_clk);
      pin_in <= ~pin_in;
    end
    repeat (10) @(posedge ref_clk);
    wr(ADDR_CTRL0, {1'b0, sel, 4'h0});
    rd(ADDR_CNT_HI, h);
    rd(ADDR_CNT_LO, d);
    chk("edges", 8'h02, d);
  endtask : t_edge
  task automatic t_sel(input logic [2:0] sel, input int e);
    wr(ADDR_CTRL0, {1'b0, sel, 4'h8});
    repeat (128) @(posedge ref_clk);
    wr(ADDR_CTRL0, {1'b0, sel, 4'h0});
    rd(ADDR_CNT_HI, h);
    rd(ADDR_CNT_LO, d);
    chk("rate", 8'h01, {7'h0, ({h, d} + 16'd2 - e[15:0]) <= 16'd4});
  endtask : t_sel
  task automatic t_pwm();
    int hi;
    wr(ADDR_CMPA_LO, 8'h09);
    wr(ADDR_CMPA_HI, 8'h00);
    wr(ADDR_CMPP_LO, 8'h03);
    wr(ADDR_CMPP_HI, 8'h00);
    for (int k = 0; k < 2; k++) begin
      hi = 0;
      wr(ADDR_CTRL1, (k == 1) ? 8'had : 8'ha9);
      wr(ADDR_CTRL0, 8'h18);
      repeat (4) @(posedge ref_clk);
      repeat (100) begin
        @(posedge ref_clk);
        #1 hi += pin_out;
      end
      wr(ADDR_CTRL0, 8'h10);
      chk("pwm high", (k == 1) ? 8'd70 : 8'd30, hi[7:0]);
    end
  endtask : t_pwm
  task automatic t_pulse();
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_CTRL1, 8'h49);
    wr(ADDR_CTRL0, 8'h68);
    repeat (20) @(posedge ref_clk);
    #1 chk("pulse idle", 8'h00, {7'h0, irq_a});
    @(posedge ref_clk);
    pin_in <= 1'b1;
    repeat (30) @(posedge ref_clk);
    #1 chk("pulse end", 8'h01, {7'h0, irq_a});
    chk("pulse pin", 8'h00, {7'h0, pin_out});
    wr(ADDR_CTRL0, 8'h60);
  endtask : t_pulse
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_buf();
    t_match();
    t_edge(3'b110, 1'b0);
    t_edge(3'b111, 1'b1);
    t_sel(3'b000, 32);
    t_sel(3'b001, 129);
    t_sel(3'b010, 8);
    t_sel(3'b011, 2);
    t_sel(3'b100, 64);
    t_sel(3'b101, 64);
    t_pwm();
    t_pulse();
    tally_and_finish();
  end
  initial begin
    #100us;
    fail_count++;
    tally_and_finish();
  end
endmodule : tmcc_core_tb_top
bind tmcc_core tmcc_core_monitor tmcc_core_monitor_inst (.ref_clk(ref_clk), .nrst(nrst),
  .clk_en(clk_en), .bus(bus), .rdata(rdata), .timer_output_pin(timer_output_pin),
  .irq_a(irq_a), .irq_p(irq_p));
